// *** core/gdf_gate_drive_fault_feedback.sv ***
`timescale 1ns/1ps
module gdf_gate_drive_fault_feedback #(
    parameter int unsigned ACK_CYCLES  = gdf_pkg::ACK_CYCLES,  // acknowledge length
    parameter int unsigned RES_CYCLES  = gdf_pkg::RES_CYCLES,  // response time
    parameter int unsigned BLK_CYCLES  = gdf_pkg::BLK_CYCLES,  // blocking time
    parameter int unsigned SHDN_CYCLES = gdf_pkg::SHDN_CYCLES  // short shutdown delay
) (
    input  wire logic i_clk,                      // 40 MHz logic clock
    input  wire logic i_srst,                     // synchronous reset, active high
    input  wire logic i_command_light_input,      // 1 = light on command fibre
    input  wire logic i_desat_over_threshold,     // 1 = switch voltage above threshold
    input  wire logic i_positive_secondary_rail_ok, // positive rail above release
    input  wire logic i_negative_secondary_rail_ok, // negative rail above release
    output logic      o_gate_on,                  // 1 = gate to positive rail
    output logic      o_gate_force_negative,      // 1 = lockout, regulate negative rail
    output logic      o_status_light_output,      // 1 = status light on (healthy)
    output logic      o_short_fault,              // short-circuit indication active
    output logic      o_supply_undervoltage_lockout // lockout active
);
    // one counter width serves every interval
    localparam int W = gdf_pkg::CNT_W;

    gdf_pkg::gdf_state_t state;
    gdf_pkg::gdf_state_t next_state;
    logic [W-1:0]        seq_cnt;
    logic [W-1:0]        next_seq_cnt;
    logic [W-1:0]        ack_cnt;
    logic                cmd_level;
    logic                cmd_rise;
    logic                cmd_fall;
    logic                lockout;
    logic                cmd_edge;
    logic                short_fault;
    logic                next_gate_on;

    // cycle count minus one, cut to counter width
    // a zero count still costs the one cycle spent deciding
    function automatic logic [W-1:0] cyc_last(input int unsigned n);
        cyc_last = (n == 0) ? '0 : W'(n - 1);
    endfunction : cyc_last

    // true in the states that carry the short-circuit indication
    function automatic logic is_short_state(input gdf_pkg::gdf_state_t s);
        is_short_state = (s == gdf_pkg::GDF_SHUTDOWN) || (s == gdf_pkg::GDF_BLOCK);
    endfunction : is_short_state

    // clean single-cycle edges from the fibre receiver
    gdf_sync_edge u_sync (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_async (i_command_light_input),
        .o_level (cmd_level),
        .o_rise  (cmd_rise),
        .o_fall  (cmd_fall)
    );

    // lockout follows the rails directly, so it also covers power-up
    assign lockout = ~(i_positive_secondary_rail_ok & i_negative_secondary_rail_ok);

    // either command edge is acknowledged the same way
    assign cmd_edge = cmd_rise | cmd_fall;

    // sequencer: on, response wait, shutdown delay, blocking
    // rises that land in shutdown or blocking are acknowledged but dropped, so
    // the controller has to send a fresh rise once the light is back; a level
    // that stays high never re-enables, which keeps a shorted switch from
    // being hammered by an automatic retry
    always_comb begin
        next_state   = state;
        next_seq_cnt = seq_cnt;
        next_gate_on = 1'b0;
        case (state)
            gdf_pkg::GDF_OFF: begin
                // only a fresh rise leaves here, never a standing high level
                if (cmd_rise) begin
                    next_state   = gdf_pkg::GDF_RESPONSE;
                    next_seq_cnt = '0;
                end
            end
            gdf_pkg::GDF_RESPONSE: begin
                next_gate_on = 1'b1;
                if (!cmd_level) begin
                    next_state = gdf_pkg::GDF_OFF;
                end else if (seq_cnt == cyc_last(RES_CYCLES)) begin
                    if (i_desat_over_threshold) begin
                        next_state   = gdf_pkg::GDF_SHUTDOWN;
                        next_seq_cnt = '0;
                    end else begin
                        next_state = gdf_pkg::GDF_ON;
                    end
                end else begin
                    next_seq_cnt = seq_cnt + 1'b1;
                end
            end
            gdf_pkg::GDF_ON: begin
                next_gate_on = 1'b1;
                if (!cmd_level) begin
                    next_state = gdf_pkg::GDF_OFF;
                end
            end
            gdf_pkg::GDF_SHUTDOWN: begin
                // gate stays on until the delay ends, even if command drops
                // blocking counts from detection, spanning both fault states
                next_gate_on = 1'b1;
                if (seq_cnt == cyc_last(SHDN_CYCLES)) begin
                    next_gate_on = 1'b0;
                end
                next_seq_cnt = seq_cnt + 1'b1;
                if (seq_cnt == cyc_last(BLK_CYCLES)) begin
                    next_state = gdf_pkg::GDF_OFF;
                end else if (seq_cnt >= cyc_last(SHDN_CYCLES)) begin
                    next_state = gdf_pkg::GDF_BLOCK;
                end
            end
            gdf_pkg::GDF_BLOCK: begin
                next_seq_cnt = seq_cnt + 1'b1;
                if (seq_cnt >= cyc_last(BLK_CYCLES)) begin
                    next_state = gdf_pkg::GDF_OFF;
                end
            end
            default: begin
                next_state = gdf_pkg::GDF_OFF;
            end
        endcase
        // lockout overrides everything and kills any pending sequence
        // an interrupted short sequence is not resumed when the rails recover
        if (lockout) begin
            next_state   = gdf_pkg::GDF_OFF;
            next_gate_on = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state   <= gdf_pkg::GDF_OFF;
            seq_cnt <= '0;
        end else begin
            state   <= next_state;
            seq_cnt <= next_seq_cnt;
        end
    end

    // indication follows the next state, as the light does, so both go dark on
    // the detecting edge and both clear together at the end of blocking
    assign short_fault = is_short_state(next_state);

    // gate drive register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_gate_on <= gdf_pkg::GATE_RESET;
        end else begin
            o_gate_on <= next_gate_on;
        end
    end

    // negative rail takeover; held during reset since the rails are unknown then
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_gate_force_negative <= gdf_pkg::FORCE_NEG_RESET;
        end else begin
            o_gate_force_negative <= lockout;
        end
    end

    // acknowledge timer, restarted by each command edge
    // the strobe cycle is itself the first dark cycle, hence one less loaded
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ack_cnt <= '0;
        end else if (cmd_edge) begin
            ack_cnt <= cyc_last(ACK_CYCLES);
        end else if (ack_cnt != '0) begin
            ack_cnt <= ack_cnt - 1'b1;
        end
    end

    // status light: dark for ack, short fault (from detection on) or lockout
    // close edges merge into one longer dark pulse the controller cannot split
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_status_light_output <= gdf_pkg::STATUS_RESET;
        end else begin
            o_status_light_output <= ~(lockout
                                      || is_short_state(next_state)
                                      || (ack_cnt != '0)
                                      || cmd_edge);
        end
    end

    // short-circuit indication register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_short_fault <= gdf_pkg::SHORT_RESET;
        end else begin
            o_short_fault <= short_fault;
        end
    end

    // lockout indication register, no timed clear
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_supply_undervoltage_lockout <= gdf_pkg::LOCKOUT_RESET;
        end else begin
            o_supply_undervoltage_lockout <= lockout;
        end
    end
endmodule : gdf_gate_drive_fault_feedback

// *** core/gdf_sync_edge.sv ***
`timescale 1ns/1ps
// two-stage synchroniser with edge strobes taken after the second stage
module gdf_sync_edge (
    input  wire logic i_clk,   // logic clock
    input  wire logic i_srst,  // synchronous reset
    input  wire logic i_async, // raw level from the optical receiver
    output logic      o_level, // synchronised level
    output logic      o_rise,  // one-cycle rising strobe
    output logic      o_fall   // one-cycle falling strobe
);
    logic meta;
    logic sync;
    logic last;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= i_async;
            sync <= meta;
            last <= sync;
        end
    end

    assign o_level = sync;
    assign o_rise  = sync & ~last;
    assign o_fall  = ~sync & last;
endmodule : gdf_sync_edge

// *** dv/gdf_ctrl_model.sv ***
`timescale 1ns/1ps
// controller: sends the command light, measures dark status runs
module gdf_ctrl_model (
    input  wire logic i_clk,                 // logic clock
    input  wire logic i_cmd,                 // requested command level
    input  wire logic i_status,              // status light seen
    output logic      o_command_light_input, // light on command fibre
    output int        o_dark_run             // length of the last dark run
);
    logic pend = 1'b0;
    int   run  = 0;
    initial o_command_light_input = 1'b0;
    initial o_dark_run = 0;
    // staged so the light never races the bench's own update
    always @(posedge i_clk) pend <= i_cmd;
    always @(negedge i_clk) o_command_light_input <= pend;
    // dark runs counted mid-cycle where the status is settled
    always @(negedge i_clk) begin
        if (!i_status) run <= run + 1;
        else begin
            if (run != 0) o_dark_run <= run;
            run <= 0;
        end
    end
endmodule : gdf_ctrl_model

// *** dv/gdf_props.sv ***
`timescale 1ns/1ps
// watches the top ports only; bound from the bench
module gdf_props #(
    parameter int unsigned BLK_CYCLES  = 30, // blocking time
    parameter int unsigned SHDN_CYCLES = 5   // short shutdown delay
) (
    input wire logic i_clk,                         // logic clock
    input wire logic i_srst,                        // synchronous reset
    input wire logic i_command_light_input,         // command fibre
    input wire logic i_desat_over_threshold,        // desaturation comparator
    input wire logic i_positive_secondary_rail_ok,  // positive rail good
    input wire logic i_negative_secondary_rail_ok,  // negative rail good
    input wire logic o_gate_on,                     // gate drive
    input wire logic o_gate_force_negative,         // negative rail takeover
    input wire logic o_status_light_output,         // status light
    input wire logic o_short_fault,                 // short indication
    input wire logic o_supply_undervoltage_lockout  // lockout indication
);
    localparam int BLK_HI  = BLK_CYCLES + 3;
    localparam int SHDN_HI = SHDN_CYCLES + 3;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // a short begins when the indication rises
    sequence s_short_start;
        $rose(o_short_fault);
    endsequence
    a_lockout_dark_off: assert property (
        !(i_positive_secondary_rail_ok && i_negative_secondary_rail_ok)
        |=> !o_gate_on && !o_status_light_output && o_supply_undervoltage_lockout)
        else $error("lockout did not darken and drop gate");
    a_lockout_neg_rail: assert property (
        o_supply_undervoltage_lockout |-> o_gate_force_negative && !o_status_light_output)
        else $error("lockout without negative rail or dark light");
    a_fault_dark: assert property (o_short_fault |-> !o_status_light_output)
        else $error("status lit during short fault");
    a_block_min: assert property (s_short_start |-> o_short_fault[*8])
        else $error("short fault cleared too early");
    a_block_clears: assert property (s_short_start |-> ##[1:BLK_HI] !o_short_fault)
        else $error("short fault did not clear");
    a_short_gate_off: assert property (s_short_start |-> ##[1:SHDN_HI] !o_gate_on)
        else $error("gate not off after shutdown delay");
    a_edge_ack: assert property ($changed(i_command_light_input)
        |-> ##[2:6] !o_status_light_output)
        else $error("command edge not acknowledged");
    a_cmd_off_gate: assert property ($fell(i_command_light_input) |-> ##[1:6] !o_gate_on)
        else $error("gate stayed on after dark command");
endmodule : gdf_props

// *** dv/test_gate_drive_fault_feedback.sv ***
`timescale 1ns/1ps
module test_gate_drive_fault_feedback;
    localparam int ACK = 4, RES = 8, BLK = 30, SHDN = 5;
    logic i_clk, i_srst, cmd, desat, pos_ok, neg_ok, light;
    logic gate_on, force_neg, status, short_fault, lockout;
    int   dark_run, error_cnt = 0, n_compared = 0, cycles = 0;
    gdf_ctrl_model gdf_ctrl_model_inst (.i_clk(i_clk), .i_cmd(cmd), .i_status(status),
        .o_command_light_input(light), .o_dark_run(dark_run));
    gdf_gate_drive_fault_feedback #(.ACK_CYCLES(ACK), .RES_CYCLES(RES), .BLK_CYCLES(BLK),
        .SHDN_CYCLES(SHDN)) gdf_gate_drive_fault_feedback_inst (.i_clk(i_clk),
        .i_srst(i_srst), .i_command_light_input(light), .i_desat_over_threshold(desat),
        .i_positive_secondary_rail_ok(pos_ok), .i_negative_secondary_rail_ok(neg_ok),
        .o_gate_on(gate_on), .o_gate_force_negative(force_neg),
        .o_status_light_output(status), .o_short_fault(short_fault),
        .o_supply_undervoltage_lockout(lockout));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // acknowledge pulse length in cycles of dark light
    function automatic int exp_ack();
        return ACK;
    endfunction : exp_ack
    task automatic cyc(input int n); repeat (n) @(negedge i_clk); endtask : cyc
    task automatic check(input string what, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("counts: %0d compared, %0d mismatches", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // hang guard, far above the expected run length
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        i_srst = 1'b1; cmd = 1'b0; desat = 1'b0; pos_ok = 1'b0; neg_ok = 1'b1;
        void'($urandom(27));
        cyc(3); i_srst = 1'b0; cyc(5);
        check("status at power-up", status, 1'b0);
        check("lockout at power-up", lockout, 1'b1);
        pos_ok = 1'b1; cyc(3);
        check("status healthy", status, 1'b1);
        $display("test power-up done");
        // random hold times between command edges
        repeat (12) begin
            cmd = ~cmd;
            cyc(5);
            check("ack dark", status, 1'b0);
            cyc(5);
            check("gate follows command", gate_on, cmd);
            cyc(10 + $urandom_range(0, 20));
            check("ack length", dark_run == exp_ack(), 1'b1);
            check("status after ack", status, 1'b1);
        end
        $display("test toggles done");
        desat = 1'b1; cmd = 1'b1; cyc(15);
        check("short detected", short_fault, 1'b1);
        check("status dark on short", status, 1'b0);
        check("gate held in delay", gate_on, 1'b1);
        cyc(SHDN + 4); desat = 1'b0;
        check("gate off after delay", gate_on, 1'b0);
        cyc(25);
        check("fault cleared", short_fault, 1'b0);
        check("status after clear", status, 1'b1);
        check("no restart on level", gate_on, 1'b0);
        cmd = 1'b0; cyc(12); cmd = 1'b1; cyc(10);
        check("restart on new edge", gate_on, 1'b1);
        $display("test short done");
        neg_ok = 1'b0; cyc(2);
        check("gate off in lockout", gate_on, 1'b0);
        check("negative rail forced", force_neg, 1'b1);
        cyc(20);
        check("lockout persists", lockout, 1'b1);
        check("status dark in lockout", status, 1'b0);
        neg_ok = 1'b1; cyc(3);
        check("status after lockout", status, 1'b1);
        $display("test lockout done");
        // command dropped inside the response wait skips the desaturation sample
        desat = 1'b1;
        cmd = 1'b0;
        cyc(12);
        cmd = 1'b1;
        cyc(6);
        check("gate on in response", gate_on, 1'b1);
        cmd = 1'b0;
        cyc(20);
        check("no short after abort", short_fault, 1'b0);
        check("gate off after abort", gate_on, 1'b0);
        desat = 1'b0;
        $display("test abort done");
        wrap_up();
    end
endmodule : test_gate_drive_fault_feedback
bind gdf_gate_drive_fault_feedback gdf_props #(.BLK_CYCLES(BLK_CYCLES),
    .SHDN_CYCLES(SHDN_CYCLES)) gdf_props_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_command_light_input(i_command_light_input),
    .i_desat_over_threshold(i_desat_over_threshold),
    .i_positive_secondary_rail_ok(i_positive_secondary_rail_ok),
    .i_negative_secondary_rail_ok(i_negative_secondary_rail_ok), .o_gate_on(o_gate_on),
    .o_gate_force_negative(o_gate_force_negative),
    .o_status_light_output(o_status_light_output), .o_short_fault(o_short_fault),
    .o_supply_undervoltage_lockout(o_supply_undervoltage_lockout));

// *** pkg/gdf_pkg.sv ***
package gdf_pkg;
    // interval defaults in cycles at 40 MHz; real values are board specific
    localparam int unsigned ACK_CYCLES      = 40;    // acknowledge dark pulse
    localparam int unsigned RES_CYCLES      = 160;   // response time after turn-on
    localparam int unsigned BLK_CYCLES      = 4000;  // fault blocking time
    localparam int unsigned SHDN_CYCLES     = 80;    // short shutdown delay
    localparam int unsigned CNT_W           = 16;    // interval counter width
    localparam logic        STATUS_RESET    = 1'b0;  // status dark during reset
    localparam logic        GATE_RESET      = 1'b0;  // gate off during reset
    localparam logic        FORCE_NEG_RESET = 1'b1;  // negative rail held during reset
    localparam logic        SHORT_RESET     = 1'b0;  // no short indication in reset
    localparam logic        LOCKOUT_RESET   = 1'b1;  // lockout shown during reset

    // main sequencer states
    typedef enum logic [2:0] {
        GDF_OFF      = 3'b000,
        GDF_RESPONSE = 3'b001,
        GDF_ON       = 3'b010,
        GDF_SHUTDOWN = 3'b011,
        GDF_BLOCK    = 3'b100
    } gdf_state_t;
endpackage : gdf_pkg
